//--- inc/spm_consts.svh
`ifndef SPM_CONSTS_SVH
`define SPM_CONSTS_SVH

// pad bit positions of the general-purpose port
`define SPM_BIT_TX1 3
`define SPM_BIT_TX0 5
`define SPM_BIT_MISO 7
`define SPM_BIT_SS 8
`define SPM_BIT_SCK 9
`define SPM_BIT_MOSI 10
`define SPM_BIT_RTS 12
`define SPM_BIT_DTR 13
`define SPM_BIT_DSR 14
`define SPM_BIT_CTS 15

// pads that have a peripheral function at all
`define SPM_SHARED_MASK 16'hf7a8
// pads taken over by the boot rom loader
`define SPM_BOOT_MASK 16'h0780
// mosi, sck and select drive at reset; everything else floats
`define SPM_RST_OE 16'h0700
// select idles high, the rest low
`define SPM_RST_OUT 16'h0100
// interrupt request positions in use
`define SPM_IRQ_MASK 6'h37
`define SPM_IRQ_IDLE 6'h00

`endif

//--- inc/spm_pkg.sv
package spm_pkg;

  typedef logic [15:0] spm_pin_vec_t;
  typedef logic [5:0] spm_irq_vec_t;

  typedef struct packed {
    spm_pin_vec_t pad_out;
    spm_pin_vec_t pad_oe;
    spm_pin_vec_t pio_in;
    logic cts_b;
    logic dsr_b;
    logic miso;
    logic rom_din;
    spm_irq_vec_t irq;
    logic nmi;
  } spm_state_t;

endpackage : spm_pkg

//--- inc/spm_pad_if.sv
`timescale 1ns/100ps
interface spm_pad_if;
  import spm_pkg::*;
  spm_pin_vec_t fsel;
  spm_pin_vec_t pio_out;
  spm_pin_vec_t pio_dir;
  spm_pin_vec_t per_out;
  spm_pin_vec_t per_oe;
  spm_pin_vec_t mux_out;
  spm_pin_vec_t mux_oe;
  modport sel (input fsel, pio_out, pio_dir, per_out, per_oe, output mux_out, mux_oe);
  modport ctl (output fsel, pio_out, pio_dir, per_out, per_oe, input mux_out, mux_oe);
endinterface : spm_pad_if

//--- hw/spm_pad_sel.sv
`timescale 1ns/100ps
module spm_pad_sel (
  spm_pad_if.sel pads
);
  import spm_pkg::*;

  // per pin: peripheral value and direction, or the gpio data and direction bits
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (pads.fsel[i]) begin
        pads.mux_out[i] = pads.per_out[i];
        pads.mux_oe[i] = pads.per_oe[i];
      end else begin
        pads.mux_out[i] = pads.pio_out[i];
        pads.mux_oe[i] = pads.pio_dir[i];
      end
    end
  end

endmodule : spm_pad_sel

//--- hw/spm_pin_mux.sv
`timescale 1ns/100ps
`include "spm_consts.svh"
module spm_pin_mux (
  input wire logic clock,
  input wire logic rst_b,
  input wire spm_pkg::spm_pin_vec_t pad_in,
  output logic [15:0] pad_out,
  output logic [15:0] pad_oe,
  input wire spm_pkg::spm_pin_vec_t pio_out,
  input wire spm_pkg::spm_pin_vec_t pio_dir,
  input wire spm_pkg::spm_pin_vec_t pio_fsel,
  output spm_pkg::spm_pin_vec_t pio_in,
  input wire logic sat_boot,
  input wire logic [1:0] uart_txd,
  input wire logic uart_dtr_b,
  input wire logic uart_rts_b,
  output logic uart_cts_b,
  output logic uart_dsr_b,
  input wire logic spi_mosi,
  input wire logic spi_sck,
  input wire logic spi_ss_b,
  output logic spi_miso,
  input wire logic rom_dout,
  input wire logic boot_rom_serial_clock,
  output logic rom_din,
  input wire logic cpu_nmi_b,
  input wire logic [5:0] cpu_int_b,
  output logic nmi_req,
  output spm_pkg::spm_irq_vec_t irq_req
);
  import spm_pkg::*;

  spm_state_t st_ff;
  spm_state_t nxt_st;
  spm_pad_if pads ();

  spm_pad_sel u_sel (
    .pads(pads.sel)
  );

  // boot overrides the per-pin select on the spi group only
  function automatic spm_pin_vec_t eff_sel(input spm_pin_vec_t fsel, input logic boot);
    eff_sel = fsel & `SPM_SHARED_MASK;
    if (boot) begin
      eff_sel = eff_sel | `SPM_BOOT_MASK;
    end
  endfunction : eff_sel

  always_comb begin
    pads.fsel = eff_sel(pio_fsel, sat_boot);
    pads.pio_out = pio_out;
    pads.pio_dir = pio_dir;
    pads.per_out = '0;
    pads.per_oe = '0;
    pads.per_out[`SPM_BIT_TX0] = uart_txd[0];
    pads.per_oe[`SPM_BIT_TX0] = 1'b1;
    pads.per_out[`SPM_BIT_TX1] = uart_txd[1];
    pads.per_oe[`SPM_BIT_TX1] = 1'b1;
    pads.per_out[`SPM_BIT_DTR] = uart_dtr_b;
    pads.per_oe[`SPM_BIT_DTR] = 1'b1;
    pads.per_out[`SPM_BIT_RTS] = uart_rts_b;
    pads.per_oe[`SPM_BIT_RTS] = 1'b1;
    pads.per_oe[`SPM_BIT_MISO] = 1'b0;
    pads.per_oe[`SPM_BIT_MOSI] = 1'b1;
    pads.per_oe[`SPM_BIT_SCK] = 1'b1;
    pads.per_oe[`SPM_BIT_SS] = 1'b1;
    if (sat_boot) begin
      pads.per_out[`SPM_BIT_MOSI] = rom_dout;
      pads.per_out[`SPM_BIT_SCK] = boot_rom_serial_clock;
      // held high so the serial device stays off the shared lines
      pads.per_out[`SPM_BIT_SS] = 1'b1;
    end else begin
      pads.per_out[`SPM_BIT_MOSI] = spi_mosi;
      pads.per_out[`SPM_BIT_SCK] = spi_sck;
      pads.per_out[`SPM_BIT_SS] = spi_ss_b;
    end
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.pad_out = pads.mux_out;
    nxt_st.pad_oe = pads.mux_oe;
    nxt_st.pio_in = pad_in;
    // deselected modem inputs read as inactive, not as pad noise
    nxt_st.cts_b = pads.fsel[`SPM_BIT_CTS] ? pad_in[`SPM_BIT_CTS] : 1'b1;
    nxt_st.dsr_b = pads.fsel[`SPM_BIT_DSR] ? pad_in[`SPM_BIT_DSR] : 1'b1;
    nxt_st.miso = 1'b0;
    nxt_st.rom_din = 1'b0;
    if (sat_boot) begin
      nxt_st.rom_din = pad_in[`SPM_BIT_MISO];
    end else if (pads.fsel[`SPM_BIT_MISO]) begin
      nxt_st.miso = pad_in[`SPM_BIT_MISO];
    end
    nxt_st.nmi = ~cpu_nmi_b;
    nxt_st.irq = ~cpu_int_b & `SPM_IRQ_MASK;
  end

  // reset image: spi outputs drive, uart and modem pads float
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_ff.pad_out <= `SPM_RST_OUT;
      st_ff.pad_oe <= `SPM_RST_OE;
      st_ff.pio_in <= '0;
      st_ff.cts_b <= 1'b1;
      st_ff.dsr_b <= 1'b1;
      st_ff.miso <= 1'b0;
      st_ff.rom_din <= 1'b0;
      st_ff.irq <= `SPM_IRQ_IDLE;
      st_ff.nmi <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pad_out = st_ff.pad_out;
  assign pad_oe = st_ff.pad_oe;
  assign pio_in = st_ff.pio_in;
  assign uart_cts_b = st_ff.cts_b;
  assign uart_dsr_b = st_ff.dsr_b;
  assign spi_miso = st_ff.miso;
  assign rom_din = st_ff.rom_din;
  assign nmi_req = st_ff.nmi;
  assign irq_req = st_ff.irq;

  tx_float_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (!pio_fsel[`SPM_BIT_TX0] && !pio_dir[`SPM_BIT_TX0]) |=> !pad_oe[`SPM_BIT_TX0])
    else $error("uart 0 transmit pad drives while not programmed");

  tx0_route_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    pio_fsel[`SPM_BIT_TX0] |=> pad_oe[`SPM_BIT_TX0] &&
      pad_out[`SPM_BIT_TX0] == $past(uart_txd[0]))
    else $error("uart 0 transmit not on its pad");

  tx1_route_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    pio_fsel[`SPM_BIT_TX1] |=> pad_oe[`SPM_BIT_TX1] &&
      pad_out[`SPM_BIT_TX1] == $past(uart_txd[1]))
    else $error("uart 1 transmit not on its pad");

  modem_route_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (pio_fsel[`SPM_BIT_RTS] && pio_fsel[`SPM_BIT_CTS]) |=>
      pad_out[`SPM_BIT_RTS] == $past(uart_rts_b) &&
      uart_cts_b == $past(pad_in[`SPM_BIT_CTS]))
    else $error("modem control pads misrouted");

  mosi_boot_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    sat_boot |=> pad_oe[`SPM_BIT_MOSI] && pad_out[`SPM_BIT_MOSI] == $past(rom_dout))
    else $error("rom data out missing on mosi pad");

  miso_boot_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    sat_boot ##1 sat_boot |=> !pad_oe[`SPM_BIT_MISO] && !spi_miso &&
      rom_din == $past(pad_in[`SPM_BIT_MISO]))
    else $error("rom data in not taken from miso pad");

  sck_drive_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (sat_boot || pio_fsel[`SPM_BIT_SCK]) |=> pad_oe[`SPM_BIT_SCK] &&
      pad_out[`SPM_BIT_SCK] == ($past(sat_boot) ? $past(boot_rom_serial_clock) :
        $past(spi_sck)))
    else $error("serial clock pad not driven by selected source");

  ss_boot_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    sat_boot |=> pad_oe[`SPM_BIT_SS] && pad_out[`SPM_BIT_SS])
    else $error("serial device selected during rom boot");

  nmi_level_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    !cpu_nmi_b ##1 !cpu_nmi_b |=> nmi_req && $past(nmi_req))
    else $error("low nmi input not seen as request");

  irq_level_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    ##1 irq_req == (~$past(cpu_int_b) & `SPM_IRQ_MASK))
    else $error("interrupt request not the inverted input");

  gpio_dir_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    !sat_boot && !pio_fsel[`SPM_BIT_SS] |=> pad_oe[`SPM_BIT_SS] == $past(pio_dir[`SPM_BIT_SS])
      && pad_oe[0] == $past(pio_dir[0]))
    else $error("gpio direction bit not applied");

  gpio_data_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    !pio_fsel[`SPM_BIT_DTR] |=> pad_out[`SPM_BIT_DTR] == $past(pio_out[`SPM_BIT_DTR])
      && pio_in == $past(pad_in))
    else $error("gpio data not on pad when peripheral off");

  tx1_float_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (!pio_fsel[`SPM_BIT_TX1] && !pio_dir[`SPM_BIT_TX1]) |=> !pad_oe[`SPM_BIT_TX1])
    else $error("uart 1 transmit pad drives while not programmed");

  modem_out_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (pio_fsel[`SPM_BIT_DTR] && pio_fsel[`SPM_BIT_DSR]) |=> pad_oe[`SPM_BIT_DTR] &&
      pad_out[`SPM_BIT_DTR] == $past(uart_dtr_b) && !pad_oe[`SPM_BIT_DSR] &&
      uart_dsr_b == $past(pad_in[`SPM_BIT_DSR]))
    else $error("dtr or dsr pad misrouted");

  modem_idle_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    !pio_fsel[`SPM_BIT_CTS] |=> uart_cts_b)
    else $error("deselected clear-to-send not idle");

  mosi_spi_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (!sat_boot && pio_fsel[`SPM_BIT_MOSI]) |=> pad_oe[`SPM_BIT_MOSI] &&
      pad_out[`SPM_BIT_MOSI] == $past(spi_mosi))
    else $error("spi data out missing on mosi pad");

  miso_spi_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (!sat_boot && pio_fsel[`SPM_BIT_MISO]) |=> !pad_oe[`SPM_BIT_MISO] && !rom_din &&
      spi_miso == $past(pad_in[`SPM_BIT_MISO]))
    else $error("spi data in not taken from miso pad");

  ss_spi_a: assert property (
    @(posedge clock) disable iff (!rst_b)
    (!sat_boot && pio_fsel[`SPM_BIT_SS]) |=> pad_oe[`SPM_BIT_SS] &&
      pad_out[`SPM_BIT_SS] == $past(spi_ss_b))
    else $error("serial select pad not driven by spi engine");

endmodule : spm_pin_mux

//--- bench/spm_far_end.sv
`timescale 1ns/100ps
module spm_far_end (
  input wire logic clock,
  input wire logic [15:0] pad_out,
  input wire logic [15:0] pad_oe,
  input wire logic [15:0] ext_out,
  input wire logic [15:0] ext_oe,
  output logic [15:0] pad_in
);
  // undriven pads wander so a stale level never reads as a match
  logic [15:0] idle_ff = 16'h5555;
  always @(posedge clock) begin
    idle_ff <= ~idle_ff;
  end
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ((ext_oe & ext_out) | (~ext_oe & idle_ff)));
endmodule : spm_far_end

//--- bench/spm_pin_mux_test.sv
`timescale 1ns/100ps
module spm_pin_mux_test;
  import spm_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  spm_pin_vec_t pad_in, pio_out, pio_dir, pio_fsel, pio_in, ext_out, ext_oe;
  logic [15:0] pad_out, pad_oe;
  logic [1:0] uart_txd;
  logic [5:0] cpu_int_b;
  spm_irq_vec_t irq_req;
  logic sat_boot, uart_dtr_b, uart_rts_b, uart_cts_b, uart_dsr_b, spi_mosi, spi_sck;
  logic spi_ss_b, spi_miso, rom_dout, boot_rom_serial_clock, rom_din, cpu_nmi_b, nmi_req;
  int fails = 0;
  int n_compared = 0;

  spm_pin_mux dut (.clock(clock), .rst_b(rst_b), .pad_in(pad_in), .pad_out(pad_out),
    .pad_oe(pad_oe), .pio_out(pio_out), .pio_dir(pio_dir), .pio_fsel(pio_fsel),
    .pio_in(pio_in), .sat_boot(sat_boot), .uart_txd(uart_txd), .uart_dtr_b(uart_dtr_b),
    .uart_rts_b(uart_rts_b), .uart_cts_b(uart_cts_b), .uart_dsr_b(uart_dsr_b),
    .spi_mosi(spi_mosi), .spi_sck(spi_sck), .spi_ss_b(spi_ss_b), .spi_miso(spi_miso),
    .rom_dout(rom_dout), .boot_rom_serial_clock(boot_rom_serial_clock), .rom_din(rom_din),
    .cpu_nmi_b(cpu_nmi_b), .cpu_int_b(cpu_int_b), .nmi_req(nmi_req), .irq_req(irq_req));
  spm_far_end far (.clock(clock), .pad_out(pad_out), .pad_oe(pad_oe), .ext_out(ext_out),
    .ext_oe(ext_oe), .pad_in(pad_in));

  initial begin
    forever #2 clock = ~clock;
  end

  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // pads loop back through the far end, so allow three edges to settle
  task step;
    repeat (3) @(negedge clock);
  endtask : step

  task stop_test;
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  task t_uart;
    pio_fsel = 16'hf028;
    ext_oe = 16'hc000;
    for (int i = 0; i < 2; i++) begin
      uart_txd = i[0] ? 2'b10 : 2'b01;
      {uart_dtr_b, uart_rts_b} = i[0] ? 2'b10 : 2'b01;
      ext_out = i[0] ? 16'h4000 : 16'h8000;
      step;
      chk("uart pad_out", i[0] ? 16'h2008 : 16'h1020, pad_out & 16'h3028);
      chk("modem in", i[0] ? 16'h0001 : 16'h0002, {14'h0, uart_cts_b, uart_dsr_b});
    end
    chk("uart pad_oe", 16'h3028, pad_oe & 16'hf028);
  endtask : t_uart

  task t_spi;
    pio_fsel = 16'h0780;
    ext_oe = 16'h0080;
    for (int i = 0; i < 2; i++) begin
      {spi_mosi, spi_sck, spi_ss_b} = i[0] ? 3'b101 : 3'b010;
      ext_out = i[0] ? 16'h0000 : 16'h0080;
      step;
      chk("spi pad_out", i[0] ? 16'h0500 : 16'h0200, pad_out & 16'h0700);
      chk("spi_miso", {15'h0, ~i[0]}, {15'h0, spi_miso});
    end
    chk("spi pad_oe", 16'h0700, pad_oe & 16'h0780);
  endtask : t_spi

  task t_boot;
    // boot must take the spi pads even with every select cleared
    pio_fsel = 16'h0000;
    sat_boot = 1'b1;
    spi_ss_b = 1'b0;
    for (int i = 0; i < 2; i++) begin
      rom_dout = i[0];
      boot_rom_serial_clock = ~i[0];
      ext_out = i[0] ? 16'h0000 : 16'h0080;
      step;
      chk("boot pad_out", i[0] ? 16'h0500 : 16'h0300, pad_out & 16'h0700);
      chk("rom_din miso", {14'h0, ~i[0], 1'b0}, {14'h0, rom_din, spi_miso});
    end
    chk("boot pad_oe", 16'h0700, pad_oe & 16'h0780);
    sat_boot = 1'b0;
  endtask : t_boot

  task t_gpio;
    // peripheral selects on pads without a peripheral must do nothing
    pio_fsel = 16'h0857;
    pio_dir = 16'h5a5a;
    pio_out = 16'h33cc;
    ext_oe = 16'ha5a5;
    ext_out = 16'h9669;
    step;
    chk("gpio pad_oe", 16'h5a5a, pad_oe);
    chk("gpio pad_out", 16'h1248, pad_out & 16'h5a5a);
    chk("gpio pio_in", 16'h9669, pio_in);
  endtask : t_gpio

  task t_irq;
    for (int i = 0; i < 6; i++) begin
      cpu_int_b = ~(6'h01 << i);
      cpu_nmi_b = i[0];
      step;
      chk("irq_req", (i == 3) ? 16'h0 : (16'h1 << i), {10'h0, irq_req});
      chk("nmi_req", {15'h0, ~i[0]}, {15'h0, nmi_req});
    end
  endtask : t_irq

  initial begin
    {sat_boot, rom_dout, boot_rom_serial_clock, spi_mosi, spi_sck} = '0;
    {uart_dtr_b, uart_rts_b, spi_ss_b, cpu_nmi_b} = '1;
    uart_txd = 2'b00;
    cpu_int_b = 6'h3f;
    {pio_out, pio_dir, pio_fsel, ext_out, ext_oe} = '0;
    repeat (10) @(negedge clock);
    chk("reset pad_oe", 16'h0700, pad_oe);
    chk("reset pad_out", 16'h0100, pad_out);
    rst_b = 1'b1;
    step;
    chk("idle pad_oe", 16'h0000, pad_oe);
    t_uart;
    t_spi;
    t_boot;
    t_gpio;
    t_irq;
    stop_test;
  end

  initial begin
    repeat (2000) @(posedge clock);
    fails++;
    stop_test;
  end
endmodule : spm_pin_mux_test
